// [rtl/cpu_data_side.sv]
// Purpose: processor data side: load/store lane steering and fifo links
// Assumes: one clock, synchronous active-low reset, partner on same clock
// Notes:   words numbered with bit 0 as the most significant bit
`include "dsteer_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1 - steer lanes for byte, halfword, word transfers
// R2 - halfword devices: byte/half; byte devices: byte
// R3 - refuse oversize transfers, never split them
// R4 - byte load: one lane into bits 24-31
// R5 - halfword load: two lanes into bits 16-31
// R6 - word load: all four lanes, enables 1111
// R7 - byte store: bits 24-31 onto addressed lane
// R8 - halfword store to lane pair; word all lanes
// R9 - narrow slaves attach on most significant lanes
// R10 - eight outgoing links with clock, push, word, flag
// R11 - eight incoming links with clock and pop
// R12 - control flag travels with every link word
// R13 - pushed word captured at next rising edge
// R14 - link fifo full high when no free entry
// R15 - incoming fifo presents head; not-empty flag
// R16 - one-cycle pop pulse removes the head word
// R17 - never push when full, pop when empty
// R18 - bit 0 is most significant everywhere; link_fifo numbers its data [WIDTH-1:0], with bit 0 least significant
// R19 - only enabled store lanes are written
module cpu_data_side (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // load/store requests from the core
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqWrite,
    input wire data_side_pkg::xfer_size_t reqSize,
    input wire data_side_pkg::xfer_size_t reqDevWidth,
    input wire data_side_pkg::word_t reqAddr,
    input wire data_side_pkg::word_t reqStoreData,
    output data_side_pkg::word_t loadData,
    output logic loadDone,
    output logic reqRefused,
    // outgoing link user side
    input wire logic [`LINK_COUNT-1:0] sendValid,
    output logic [`LINK_COUNT-1:0] sendReady,
    input wire logic [`LINK_COUNT-1:0][0:`WORD_BITS-1] sendWord,
    input wire logic [`LINK_COUNT-1:0] sendCtrl,
    // incoming link user side
    output logic [`LINK_COUNT-1:0] recvValid,
    input wire logic [`LINK_COUNT-1:0] recvTake,
    output logic [`LINK_COUNT-1:0][0:`WORD_BITS-1] recvWord,
    output logic [`LINK_COUNT-1:0] recvCtrl,
    // bus and links toward the partners
    data_side_if.cpu bus
);

    // ============================================================
    // steering functions
    function automatic data_side_pkg::lanes_t laneEnables(
        input data_side_pkg::xfer_size_t sz,
        input logic [0:1] a
    );
        case (sz)
            data_side_pkg::SIZE_BYTE: laneEnables = `BE_BYTE0 >> a; // R4 R7
            data_side_pkg::SIZE_HALF:
                laneEnables = a[0] ? `BE_HALF_LO : `BE_HALF_HI; // R5 R8
            default: laneEnables = `BE_WORD; // R6
        endcase
    endfunction

    // store data is replicated; the enables mark the valid lanes
    function automatic data_side_pkg::word_t steerStore(
        input data_side_pkg::xfer_size_t sz,
        input data_side_pkg::word_t src
    );
        case (sz)
            data_side_pkg::SIZE_BYTE: steerStore = {4{src[24:31]}}; // R7 R19
            data_side_pkg::SIZE_HALF: steerStore = {2{src[16:31]}}; // R8 R19
            default: steerStore = src; // R8
        endcase
    endfunction

    function automatic data_side_pkg::word_t steerLoad(
        input data_side_pkg::xfer_size_t sz,
        input logic [0:1] a,
        input data_side_pkg::word_t rd
    );
        data_side_pkg::word_t d;
        d = `WORD_RESET;
        case (sz)
            data_side_pkg::SIZE_BYTE: d[24:31] = rd[8*a +: 8]; // R4 R18
            data_side_pkg::SIZE_HALF: d[16:31] = rd[16*a[0] +: 16]; // R5
            default: d = rd; // R6
        endcase
        steerLoad = d;
    endfunction

    // ============================================================
    // request checks
    logic [0:1] reqLane;
    logic aligned;
    logic fitsDevice;
    logic takeReq;
    data_side_pkg::bus_state_t state;
    data_side_pkg::xfer_size_t accSize;
    logic [0:1] accLane;

    assign reqLane = reqAddr[30:31];
    always_comb begin
        case (reqSize)
            data_side_pkg::SIZE_BYTE: aligned = 1'b1;
            data_side_pkg::SIZE_HALF: aligned = !reqLane[1];
            default: aligned = (reqLane == 2'h0);
        endcase
    end
    // wider than the device is refused outright, no conversion cycles
    assign fitsDevice = (reqSize <= reqDevWidth); // R2 R3 R9
    assign reqReady = (state == data_side_pkg::BUS_IDLE);
    assign takeReq = reqValid && reqReady;

    // ============================================================
    // bus sequencer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= data_side_pkg::BUS_IDLE;
        end else begin
            case (state)
                data_side_pkg::BUS_IDLE: begin
                    if (takeReq && aligned && fitsDevice) begin // R3
                        state <= data_side_pkg::BUS_WAIT;
                    end
                end
                data_side_pkg::BUS_WAIT: begin
                    if (bus.busReady) begin
                        state <= data_side_pkg::BUS_IDLE;
                    end
                end
                default: state <= data_side_pkg::BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            bus.busAddrStrobe <= 1'b0;
            bus.busReadStrobe <= 1'b0;
            bus.busWriteStrobe <= 1'b0;
        end else if (takeReq && aligned && fitsDevice) begin
            bus.busAddrStrobe <= 1'b1;
            bus.busReadStrobe <= !reqWrite;
            bus.busWriteStrobe <= reqWrite;
        end else begin
            bus.busAddrStrobe <= 1'b0;
            if (bus.busReady && state == data_side_pkg::BUS_WAIT) begin
                bus.busReadStrobe <= 1'b0;
                bus.busWriteStrobe <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            bus.busAddr <= `WORD_RESET;
            bus.busByteEn <= `BE_NONE;
            bus.busWrData <= `WORD_RESET;
            accSize <= data_side_pkg::SIZE_WORD;
            accLane <= 2'h0;
        end else if (takeReq && aligned && fitsDevice) begin
            bus.busAddr <= reqAddr;
            bus.busByteEn <= laneEnables(reqSize, reqLane); // R1
            bus.busWrData <= reqWrite ? steerStore(reqSize, reqStoreData)
                                      : `WORD_RESET; // R1
            accSize <= reqSize;
            accLane <= reqLane;
        end
    end

    // ============================================================
    // answers to the core
    always_ff @(posedge clk) begin
        if (!nrst) begin
            loadData <= `WORD_RESET;
        end else if (state == data_side_pkg::BUS_WAIT && bus.busReady &&
                     bus.busReadStrobe) begin
            loadData <= steerLoad(accSize, accLane, bus.busRdData); // R1
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            loadDone <= 1'b0;
            reqRefused <= 1'b0;
        end else begin
            loadDone <= (state == data_side_pkg::BUS_WAIT) && bus.busReady;
            reqRefused <= takeReq && !(aligned && fitsDevice); // R3
        end
    end

    // ============================================================
    // fifo links, one slice per channel
    for (genvar i = 0; i < `LINK_COUNT; i++) begin : g_link
        logic outPending;
        data_side_pkg::word_t outHeld;
        logic outHeldCtrl;
        logic outPush;
        logic inHeld;
        data_side_pkg::word_t inWord;
        logic inCtrl;
        logic inPop;

        // both links run on the core clock
        assign bus.linkOutClock[i] = clk; // R10
        assign bus.linkInClock[i] = clk; // R11

        // outgoing: one holding stage, pushed only while not full
        assign outPush = outPending && !bus.linkOutFull[i]; // R17
        assign sendReady[i] = !outPending || outPush;
        assign bus.linkOutPush[i] = outPush; // R13
        assign bus.linkOutWord[i] = outHeld; // R10
        assign bus.linkOutCtrlFlag[i] = outHeldCtrl; // R12

        always_ff @(posedge clk) begin
            if (!nrst) begin
                outPending <= 1'b0;
            end else if (sendValid[i] && sendReady[i]) begin
                outPending <= 1'b1;
            end else if (outPush) begin
                outPending <= 1'b0;
            end
        end

        always_ff @(posedge clk) begin
            if (!nrst) begin
                outHeld <= `WORD_RESET;
                outHeldCtrl <= 1'b0;
            end else if (sendValid[i] && sendReady[i]) begin
                outHeld <= sendWord[i];
                outHeldCtrl <= sendCtrl[i]; // R12
            end
        end

        // incoming: pop one pulse per word into a holding stage
        assign inPop = bus.linkInNotEmpty[i] && (!inHeld || recvTake[i]); // R16 R17
        assign bus.linkInPop[i] = inPop; // R11

        always_ff @(posedge clk) begin
            if (!nrst) begin
                inHeld <= 1'b0;
            end else if (inPop) begin
                inHeld <= 1'b1;
            end else if (recvTake[i]) begin
                inHeld <= 1'b0;
            end
        end

        always_ff @(posedge clk) begin
            if (!nrst) begin
                inWord <= `WORD_RESET;
                inCtrl <= 1'b0;
            end else if (inPop) begin
                inWord <= bus.linkInWord[i]; // R15
                inCtrl <= bus.linkInCtrlFlag[i]; // R12
            end
        end

        assign recvValid[i] = inHeld;
        assign recvWord[i] = inWord;
        assign recvCtrl[i] = inCtrl;
    end

endmodule // cpu_data_side

`default_nettype wire

// [rtl/dsteer_cfg.svh]
// Purpose: shared constants for the data-side steering and fifo links
// Assumes: included by bare name from every rtl file
// Notes:   guarded against double inclusion
`ifndef DSTEER_CFG_SVH
`define DSTEER_CFG_SVH

// ============================================================
// widths and counts
`define WORD_BITS 32
`define LANE_COUNT 4
`define LINK_COUNT 8
`define LINK_FIFO_DEPTH 8
`define LINK_FIFO_WIDTH 33
`define MEM_INDEX_BITS 4
`define MEM_WORDS 16

// ============================================================
// byte enable patterns, bit 0 is lane 0 (most significant lane)
`define BE_NONE 4'h0
`define BE_BYTE0 4'h8
`define BE_HALF_HI 4'hc
`define BE_HALF_LO 4'h3
`define BE_WORD 4'hf

// ============================================================
// reset values
`define WORD_RESET 32'h00000000

`endif

// [rtl/data_side_pkg.sv]
// Purpose: types used by the processor end of the data side and by the bench
// Assumes: dsteer_cfg.svh on the include path
// Notes:   bit 0 of every word is its most significant bit
`include "dsteer_cfg.svh"

package data_side_pkg;
    typedef logic [0:`WORD_BITS-1] word_t;
    typedef logic [0:`LANE_COUNT-1] lanes_t;
    // ordered narrowest first so sizes compare by width
    typedef enum logic [1:0] {SIZE_BYTE, SIZE_HALF, SIZE_WORD} xfer_size_t;
    typedef enum logic [0:0] {BUS_IDLE, BUS_WAIT} bus_state_t;
endpackage

// [rtl/data_side_if.sv]
// Purpose: wires between the processor data side and its partners
// Assumes: one clock shared by both ends
// Notes:   local data bus plus eight outgoing and eight incoming links
`include "dsteer_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

interface data_side_if;
    // data bus
    logic [0:`WORD_BITS-1] busAddr;
    logic [0:`LANE_COUNT-1] busByteEn;
    logic [0:`WORD_BITS-1] busWrData;
    logic busAddrStrobe;
    logic busReadStrobe;
    logic busWriteStrobe;
    logic [0:`WORD_BITS-1] busRdData;
    logic busReady;
    // outgoing links
    logic [`LINK_COUNT-1:0] linkOutClock;
    logic [`LINK_COUNT-1:0] linkOutPush;
    logic [`LINK_COUNT-1:0][0:`WORD_BITS-1] linkOutWord;
    logic [`LINK_COUNT-1:0] linkOutCtrlFlag;
    logic [`LINK_COUNT-1:0] linkOutFull;
    // incoming links
    logic [`LINK_COUNT-1:0] linkInClock;
    logic [`LINK_COUNT-1:0] linkInPop;
    logic [`LINK_COUNT-1:0][0:`WORD_BITS-1] linkInWord;
    logic [`LINK_COUNT-1:0] linkInCtrlFlag;
    logic [`LINK_COUNT-1:0] linkInNotEmpty;

    modport cpu (
        output busAddr, busByteEn, busWrData, busAddrStrobe,
        output busReadStrobe, busWriteStrobe,
        input busRdData, busReady,
        output linkOutClock, linkOutPush, linkOutWord, linkOutCtrlFlag,
        input linkOutFull,
        output linkInClock, linkInPop,
        input linkInWord, linkInCtrlFlag, linkInNotEmpty
    );

    modport partner (
        input busAddr, busByteEn, busWrData, busAddrStrobe,
        input busReadStrobe, busWriteStrobe,
        output busRdData, busReady,
        input linkOutClock, linkOutPush, linkOutWord, linkOutCtrlFlag,
        output linkOutFull,
        input linkInClock, linkInPop,
        output linkInWord, linkInCtrlFlag, linkInNotEmpty
    );
endinterface

`default_nettype wire

// [rtl/link_partner.sv]
// Purpose: far end: word-wide bus slave memory and the link fifos
// Assumes: same clock as the processor; link clocks are that clock
// Notes:   fifo module lives here with the only end that instantiates it
`include "dsteer_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// fifo with valid/ready on both sides
module link_fifo #(
    parameter int WIDTH = `LINK_FIFO_WIDTH,
    parameter int DEPTH = `LINK_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] FULLCOUNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [CW-1:0] count;
    logic doWr;
    logic doRd;

    assign inReady = (count != FULLCOUNT); // R14
    assign outValid = (count != '0); // R15
    assign outData = mem[rdPtr]; // R15
    assign doWr = inValid && inReady;
    assign doRd = outValid && outReady;

    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr] <= inData; // R13
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            if (doWr) begin
                wrPtr <= (wrPtr == LAST) ? '0 : wrPtr + 1'b1;
            end
            if (doRd) begin
                rdPtr <= (rdPtr == LAST) ? '0 : rdPtr + 1'b1; // R16
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            count <= '0;
        end else begin
            case ({doWr, doRd})
                2'b10: count <= count + 1'b1;
                2'b01: count <= count - 1'b1;
                default: count <= count;
            endcase
        end
    end
endmodule // link_fifo

// ============================================================
// partner end
module link_partner (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // words leaving the outgoing links
    output logic [`LINK_COUNT-1:0] drainValid,
    input wire logic [`LINK_COUNT-1:0] drainReady,
    output logic [`LINK_COUNT-1:0][0:`WORD_BITS-1] drainWord,
    output logic [`LINK_COUNT-1:0] drainCtrl,
    // words entering the incoming links
    input wire logic [`LINK_COUNT-1:0] fillValid,
    output logic [`LINK_COUNT-1:0] fillReady,
    input wire logic [`LINK_COUNT-1:0][0:`WORD_BITS-1] fillWord,
    input wire logic [`LINK_COUNT-1:0] fillCtrl,
    // processor side
    data_side_if.partner bus
);
    logic [0:`WORD_BITS-1] mem [`MEM_WORDS];
    logic [`MEM_INDEX_BITS-1:0] index;
    logic access;

    // word-wide slave, so every lane pattern is served
    assign index = bus.busAddr[`WORD_BITS-2-`MEM_INDEX_BITS +: `MEM_INDEX_BITS];
    assign access = bus.busAddrStrobe;

    always_ff @(posedge clk) begin
        if (access && bus.busWriteStrobe) begin
            for (int l = 0; l < `LANE_COUNT; l++) begin
                if (bus.busByteEn[l]) begin
                    mem[index][8*l +: 8] <= bus.busWrData[8*l +: 8]; // R19
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            bus.busRdData <= `WORD_RESET;
            bus.busReady <= 1'b0;
        end else begin
            bus.busReady <= access;
            if (access && bus.busReadStrobe) begin
                bus.busRdData <= mem[index];
            end
        end
    end

    for (genvar i = 0; i < `LINK_COUNT; i++) begin : g_link
        logic outRoom;

        link_fifo #(.WIDTH(`LINK_FIFO_WIDTH), .DEPTH(`LINK_FIFO_DEPTH)) u_out (
            .clk(clk),
            .nrst(nrst),
            .inValid(bus.linkOutPush[i]), // R13
            .inReady(outRoom),
            .inData({bus.linkOutCtrlFlag[i], bus.linkOutWord[i]}), // R12
            .outValid(drainValid[i]),
            .outReady(drainReady[i]),
            .outData({drainCtrl[i], drainWord[i]})
        );
        assign bus.linkOutFull[i] = !outRoom; // R14

        link_fifo #(.WIDTH(`LINK_FIFO_WIDTH), .DEPTH(`LINK_FIFO_DEPTH)) u_in (
            .clk(clk),
            .nrst(nrst),
            .inValid(fillValid[i]),
            .inReady(fillReady[i]),
            .inData({fillCtrl[i], fillWord[i]}), // R12
            .outValid(bus.linkInNotEmpty[i]), // R15
            .outReady(bus.linkInPop[i]), // R16
            .outData({bus.linkInCtrlFlag[i], bus.linkInWord[i]})
        );
    end
endmodule // link_partner

`default_nettype wire

// [bench/data_side_checker.sv]
// Purpose: concurrent checks on the bus and link wires between both ends
// Assumes: one clock, synchronous active-low reset held two cycles or more
// Notes:   partner answers every bus access one cycle after the strobe
`include "dsteer_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module data_side_checker (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // data bus
    input wire logic [0:`WORD_BITS-1] busAddr,
    input wire logic [0:`LANE_COUNT-1] busByteEn,
    input wire logic busAddrStrobe,
    input wire logic busReadStrobe,
    input wire logic busWriteStrobe,
    input wire logic busReady,
    // links
    input wire logic [`LINK_COUNT-1:0] linkOutPush,
    input wire logic [`LINK_COUNT-1:0] linkOutFull,
    input wire logic [`LINK_COUNT-1:0] linkInPop,
    input wire logic [`LINK_COUNT-1:0] linkInNotEmpty
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ============================================================
    // bus transfers
    sequence s_hold(st);
        st ##1 (st && busReady && !busAddrStrobe) ##1 !st;
    endsequence
    property p_readHold;
        busAddrStrobe && busReadStrobe |-> s_hold(busReadStrobe);
    endproperty
    a_readHold: assert property (p_readHold)
        else $error("read strobe timing wrong");
    property p_writeHold;
        busAddrStrobe && busWriteStrobe |-> s_hold(busWriteStrobe);
    endproperty
    a_writeHold: assert property (p_writeHold)
        else $error("write strobe timing wrong");
    property p_legal;
        busAddrStrobe |-> busByteEn inside {4'h8, 4'h4, 4'h2, 4'h1,
            4'hc, 4'h3, 4'hf};
    endproperty
    a_legal: assert property (p_legal)
        else $error("illegal byte enables");
    property p_byteLane;
        busAddrStrobe && $onehot(busByteEn)
            |-> busByteEn == (4'h8 >> busAddr[30:31]);
    endproperty
    a_byteLane: assert property (p_byteLane)
        else $error("byte lane does not match address");
    property p_halfLane;
        busAddrStrobe && busByteEn inside {4'hc, 4'h3} |-> !busAddr[31]
            && busByteEn == (busAddr[30] ? 4'h3 : 4'hc);
    endproperty
    a_halfLane: assert property (p_halfLane)
        else $error("halfword lanes do not match address");
    property p_wordLane;
        busAddrStrobe && busByteEn == 4'hf |-> busAddr[30:31] == 2'h0;
    endproperty
    a_wordLane: assert property (p_wordLane)
        else $error("word access not aligned");

    // ============================================================
    // links
    property p_pushSafe;
        (linkOutPush & linkOutFull) == '0;
    endproperty
    a_pushSafe: assert property (p_pushSafe)
        else $error("push while full");
    property p_popSafe;
        (linkInPop & ~linkInNotEmpty) == '0;
    endproperty
    a_popSafe: assert property (p_popSafe)
        else $error("pop while empty");
    property p_fullCause;
        $past(nrst) |->
            (linkOutFull & ~$past(linkOutFull) & ~$past(linkOutPush)) == '0;
    endproperty
    a_fullCause: assert property (p_fullCause)
        else $error("full rose without a push");
    property p_emptyCause;
        $past(nrst) |-> (~linkInNotEmpty & $past(linkInNotEmpty)
            & ~$past(linkInPop)) == '0;
    endproperty
    a_emptyCause: assert property (p_emptyCause)
        else $error("word vanished without a pop");
endmodule // data_side_checker

`default_nettype wire

// [bench/tb.sv]
// Purpose: self-checking bench joining the processor end to the partner end
// Assumes: partner memory word 0 serves addresses 0 to 3
// Notes:   each link holds fifo depth plus one holding stage
`include "dsteer_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam data_side_pkg::xfer_size_t B = data_side_pkg::SIZE_BYTE;
    localparam data_side_pkg::xfer_size_t H = data_side_pkg::SIZE_HALF;
    localparam data_side_pkg::xfer_size_t W = data_side_pkg::SIZE_WORD;
    localparam int CAP = `LINK_FIFO_DEPTH + 1;
    typedef struct {
        logic wr;
        data_side_pkg::xfer_size_t sz, dev;
        logic [1:0] a;
        logic [31:0] d;
        logic rf;
    } row_t;
    logic clk = 1'h0, nrst = 1'h0;
    logic reqValid, reqReady, reqWrite, loadDone, reqRefused;
    data_side_pkg::xfer_size_t reqSize, reqDevWidth;
    data_side_pkg::word_t reqAddr, reqStoreData, loadData;
    logic [`LINK_COUNT-1:0] sendValid, sendReady, sendCtrl;
    logic [`LINK_COUNT-1:0] recvValid, recvTake, recvCtrl;
    logic [`LINK_COUNT-1:0] drainValid, drainReady, drainCtrl;
    logic [`LINK_COUNT-1:0] fillValid, fillReady, fillCtrl;
    logic [`LINK_COUNT-1:0][0:`WORD_BITS-1] sendWord, recvWord;
    logic [`LINK_COUNT-1:0][0:`WORD_BITS-1] drainWord, fillWord;
    int nErrors = 0, nCompared = 0;
    // load rows carry the expected result, store rows the source
    row_t rows [] = '{
        '{1'h1, W, W, 2'h0, 32'h11223344, 1'h0},
        '{1'h0, W, W, 2'h0, 32'h11223344, 1'h0},
        '{1'h0, B, W, 2'h0, 32'h00000011, 1'h0},
        '{1'h0, B, W, 2'h1, 32'h00000022, 1'h0},
        '{1'h0, B, W, 2'h2, 32'h00000033, 1'h0},
        '{1'h0, B, W, 2'h3, 32'h00000044, 1'h0},
        '{1'h0, H, W, 2'h0, 32'h00001122, 1'h0},
        '{1'h0, H, W, 2'h2, 32'h00003344, 1'h0},
        '{1'h1, B, W, 2'h1, 32'hdeadbeaa, 1'h0},
        '{1'h1, B, W, 2'h2, 32'h123456bb, 1'h0},
        '{1'h1, H, W, 2'h2, 32'h5555ccdd, 1'h0},
        '{1'h1, H, W, 2'h0, 32'haaaaeeff, 1'h0},
        '{1'h1, B, B, 2'h0, 32'h00000099, 1'h0},
        '{1'h1, B, W, 2'h3, 32'hffffff77, 1'h0},
        '{1'h0, W, W, 2'h0, 32'h99ffcc77, 1'h0},
        '{1'h0, H, H, 2'h0, 32'h000099ff, 1'h0},
        '{1'h0, B, B, 2'h0, 32'h00000099, 1'h0},
        '{1'h0, H, B, 2'h0, 32'h0, 1'h1},
        '{1'h0, W, H, 2'h0, 32'h0, 1'h1},
        '{1'h0, H, W, 2'h1, 32'h0, 1'h1},
        '{1'h0, W, W, 2'h2, 32'h0, 1'h1},
        '{1'h1, W, H, 2'h0, 32'h0, 1'h1},
        '{1'h0, W, W, 2'h0, 32'h99ffcc77, 1'h0}
    };

    always #2.5 clk = ~clk;

    data_side_if dsi();
    cpu_data_side i_cpu_data_side (.clk, .nrst, .reqValid, .reqReady,
        .reqWrite, .reqSize, .reqDevWidth, .reqAddr, .reqStoreData,
        .loadData, .loadDone, .reqRefused, .sendValid, .sendReady,
        .sendWord, .sendCtrl, .recvValid, .recvTake, .recvWord, .recvCtrl,
        .bus(dsi));
    link_partner i_link_partner (.clk, .nrst, .drainValid, .drainReady,
        .drainWord, .drainCtrl, .fillValid, .fillReady, .fillWord,
        .fillCtrl, .bus(dsi));
    data_side_checker i_data_side_checker (.clk, .nrst,
        .busAddr(dsi.busAddr), .busByteEn(dsi.busByteEn),
        .busAddrStrobe(dsi.busAddrStrobe), .busReady(dsi.busReady),
        .busReadStrobe(dsi.busReadStrobe),
        .busWriteStrobe(dsi.busWriteStrobe),
        .linkOutPush(dsi.linkOutPush), .linkOutFull(dsi.linkOutFull),
        .linkInPop(dsi.linkInPop), .linkInNotEmpty(dsi.linkInNotEmpty));

    // ============================================================
    // tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
            nErrors++;
        end
    endtask

    task automatic summarize();
        $display("compared %0d errors %0d", nCompared, nErrors);
        if (nErrors == 0 && nCompared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one core access, entered and left at a falling edge
    task automatic access(input row_t r);
        logic sawAs, done, refu;
        int n;
        {reqValid, reqWrite} = {1'h1, r.wr};
        reqSize = r.sz;
        reqDevWidth = r.dev;
        reqAddr = {30'h0, r.a};
        reqStoreData = r.d;
        for (n = 0; n < 20 && reqReady !== 1'h1; n++) @(negedge clk);
        @(negedge clk);
        reqValid = 1'h0;
        {sawAs, done, refu} = 3'h0;
        for (n = 0; n < 10; n++) begin
            sawAs |= dsi.busAddrStrobe === 1'h1;
            done = loadDone === 1'h1;
            refu = reqRefused === 1'h1;
            if (done || refu) break;
            @(negedge clk);
        end
        if (!(done || refu)) begin
            nErrors++;
            summarize();
        end
        chk(refu, r.rf);
        chk(sawAs, !r.rf);
        if (!r.wr && !r.rf) chk(loadData, r.d);
    endtask

    // fill one link until it has taken CAP words, check it refuses more, then drain it in order
    task automatic stream(input int k, input bit dir);
        int acc, got;
        logic [31:0] w;
        {acc, got} = '0;
        for (int n = 0; n < 40 && acc < CAP; n++) begin
            w = 32'hc0de0000 | (k << 8) | acc;
            if (dir) {fillValid[k], fillCtrl[k], fillWord[k]} = {1'h1, acc[0], w};
            else {sendValid[k], sendCtrl[k], sendWord[k]} = {1'h1, acc[0], w};
            if ((dir ? fillReady[k] : sendReady[k]) === 1'h1) acc++;
            @(negedge clk);
        end
        {fillValid[k], sendValid[k]} = 2'h0;
        repeat (2) @(negedge clk);
        chk(acc, CAP);
        chk(dir ? fillReady[k] : sendReady[k], 1'h0);
        chk(dir ? dsi.linkInNotEmpty[k] : dsi.linkOutFull[k], 1'h1);
        if (dir) recvTake[k] = 1'h1;
        else drainReady[k] = 1'h1;
        for (int n = 0; n < 40 && got < acc; n++) begin
            if ((dir ? recvValid[k] : drainValid[k]) === 1'h1) begin
                w = 32'hc0de0000 | (k << 8) | got;
                chk(dir ? recvWord[k] : drainWord[k], w);
                chk(dir ? recvCtrl[k] : drainCtrl[k], got[0]);
                got++;
            end
            @(negedge clk);
        end
        {recvTake[k], drainReady[k]} = 2'h0;
        chk(got, acc);
        chk(dsi.linkOutFull[k] | dsi.linkInNotEmpty[k], 1'h0);
    endtask

    // ============================================================
    // main sequence
    initial begin
        {reqValid, reqWrite, sendValid, sendCtrl, recvTake, reqAddr} = '0;
        {drainReady, fillValid, fillCtrl, sendWord, fillWord, reqStoreData} = '0;
        reqSize = B;
        reqDevWidth = W;
        repeat (5) @(negedge clk);
        nrst = 1'h1;
        chk({loadDone, reqRefused, dsi.busAddrStrobe, dsi.busByteEn}, 0);
        chk(dsi.linkOutFull | dsi.linkInNotEmpty | recvValid, 0);
        chk(fillReady, 8'hff);
        foreach (rows[i]) access(rows[i]);
        for (int k = 0; k < `LINK_COUNT; k++) begin
            stream(k, 1'b0);
            stream(k, 1'b1);
        end
        // reset with words in flight empties every link
        {sendValid[2], fillValid[5]} = 2'h3;
        repeat (3) @(negedge clk);
        {nrst, sendValid, fillValid} = '0;
        repeat (2) @(negedge clk);
        nrst = 1'h1;
        chk(drainValid | dsi.linkInNotEmpty | recvValid, 0);
        access(rows[22]);
        summarize();
    end
endmodule // tb

`default_nettype wire
